// [hdl/lock_holdover_pkg.sv]
package lock_holdover_pkg;

   // Field widths.
   localparam int COUNT_W  = 14;
   localparam int PHASE_W  = 8;
   localparam int DAC_W    = 10;
   localparam int MODE_W   = 2;

   // Holdover mode selection code that enables holdover.
   localparam logic [MODE_W-1:0] MODE_HOLDOVER_ON = 2'h2;

   // Reset values.
   localparam logic [DAC_W-1:0]   RST_DAC_CODE   = 10'h200;
   localparam logic [COUNT_W-1:0] RST_LOCK_COUNT = 14'h0000;

   // Cycles the holdover exit waits for a valid reference before restarting lock.
   localparam int EXIT_WAIT_CYCLES = 2;

   typedef enum logic [1:0] {
      ST_ACQUIRE  = 2'b00,
      ST_LOCKED   = 2'b01,
      ST_HOLDOVER = 2'b11
   } loop_state_t;

endpackage

// [hdl/lock_qualifier.sv]
`timescale 1ns/1ns
`default_nettype none
module lock_qualifier
   import lock_holdover_pkg::*;
#(
   parameter int CNT_W = COUNT_W
) (
   // Clock and reset.
   input  wire logic             core_clk_in,
   input  wire logic             arst_n_in,
   // Qualification inputs.
   input  wire logic             restart_in,
   input  wire logic             in_window_in,
   input  wire logic [CNT_W-1:0] lock_qualify_count_in,
   // Result.
   output logic                  lock_flag_out
);
   // A one-bit counter could not tell an empty run from a met count of one.
   if (CNT_W < 2) begin : g_bad_count_width
      $error("lock_qualifier: CNT_W too small");
   end

   logic [CNT_W-1:0] run_count;
   logic [CNT_W-1:0] next_run_count;
   logic             lock_flag;
   logic             next_lock_flag;

   always_comb begin
      next_run_count = run_count;
      next_lock_flag = lock_flag;
      if (restart_in || !in_window_in) begin
         next_run_count = '0; // R11
         next_lock_flag = 1'b0; // R3
      end else if (run_count >= lock_qualify_count_in) begin
         next_lock_flag = 1'b1; // R2
      end else begin
         next_run_count = run_count + CNT_W'(1); // R1
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         run_count <= '0;
         lock_flag <= 1'b0;
      end else begin
         run_count <= next_run_count;
         lock_flag <= next_lock_flag;
      end
   end

   assign lock_flag_out = lock_flag;

   a_drop_outside: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !in_window_in |=> !lock_flag_out) // R3
      else $error("lock flag stayed high outside window");
   a_count_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !in_window_in |=> run_count == '0) // R11
      else $error("qualify counter not cleared");
   a_lock_needs_count: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      $rose(lock_flag_out) |-> $past(run_count) >= $past(lock_qualify_count_in)) // R1
      else $error("lock declared before count met");
endmodule
`default_nettype wire

// [hdl/pll_lock_detect_holdover.sv]
// Summary of operation
// R1 - Lock time set by programmed qualify count.
// R2 - Lock flag rises after window dwell count.
// R3 - Lock flag drops when phase leaves window.
// R4 - Low lock flag enters holdover unless disabled.
// R5 - Valid reference exits holdover, restarts locking.
// R6 - Mode code two enables holdover.
// R7 - Tracking off freezes holdover DAC value.
// R8 - Manual DAC enable uses fixed code.
// R9 - Code 512 gives about half supply.
// R10 - Software picks count large against chattering.
// R11 - Counter clears whenever phase leaves window.
`timescale 1ns/1ns
`default_nettype none
module pll_lock_detect_holdover
   import lock_holdover_pkg::*;
#(
   parameter int CNT_W = COUNT_W,
   parameter int PH_W  = PHASE_W,
   parameter int D_W   = DAC_W
) (
   // Clock and reset.
   input  wire logic             core_clk_in,
   input  wire logic             arst_n_in,
   // Phase detector observations, one sample per phase-detector cycle.
   input  wire logic [PH_W-1:0]  phase_error_in,
   input  wire logic             ref_valid_in,
   input  wire logic [D_W-1:0]   loop_dac_in,
   // Configuration.
   input  wire logic [CNT_W-1:0] lock_qualify_count_in,
   input  wire logic [PH_W-1:0]  phase_window_size_in,
   input  wire logic             lock_loss_trigger_off_in,
   input  wire logic [MODE_W-1:0] holdover_mode_in,
   input  wire logic             track_enable_in,
   input  wire logic             fixed_voltage_enable_in,
   input  wire logic [D_W-1:0]   fixed_voltage_code_in,
   // Status and control outputs.
   output logic                  lock_flag_out,
   output logic                  holdover_out,
   output logic                  loop_restart_out,
   output logic [D_W-1:0]        vcxo_dac_out
);
   // The exit wait counter is two bits wide, and the half-supply code needs a
   // DAC of at least ten bits.
   if (D_W < 10) begin : g_bad_dac_width
      $error("pll_lock_detect_holdover: D_W below 10");
   end
   if (PH_W < 1) begin : g_bad_phase_width
      $error("pll_lock_detect_holdover: PH_W too small");
   end
   if (EXIT_WAIT_CYCLES < 1 || EXIT_WAIT_CYCLES > 4) begin : g_bad_exit_wait
      $error("pll_lock_detect_holdover: EXIT_WAIT_CYCLES out of range");
   end

   // The reference-valid pin is asynchronous to this clock.
   logic ref_sync_a;
   logic ref_sync_b;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ref_sync_a <= 1'b0;
         ref_sync_b <= 1'b0;
      end else begin
         ref_sync_a <= ref_valid_in;
         ref_sync_b <= ref_sync_a;
      end
   end

   logic in_window;
   logic lock_flag;
   logic restart;

   assign in_window = phase_error_in <= phase_window_size_in;

   lock_qualifier #(
      .CNT_W (CNT_W)
   ) u_qual (
      .core_clk_in           (core_clk_in),
      .arst_n_in             (arst_n_in),
      .restart_in            (restart),
      .in_window_in          (in_window),
      .lock_qualify_count_in (lock_qualify_count_in),
      .lock_flag_out         (lock_flag)
   );

   loop_state_t state;
   loop_state_t next_state;
   logic [1:0]  exit_wait;
   logic [1:0]  next_exit_wait;
   logic [D_W-1:0] dac;
   logic [D_W-1:0] next_dac;
   logic        holdover_on;
   logic        trigger;

   assign holdover_on = holdover_mode_in == MODE_HOLDOVER_ON; // R6
   assign trigger = holdover_on && !lock_loss_trigger_off_in; // R4

   always_comb begin
      next_state     = state;
      next_exit_wait = exit_wait;
      restart        = 1'b0;
      unique case (state)
         ST_ACQUIRE: begin
            if (lock_flag) begin
               next_state = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            if (!lock_flag && trigger) begin
               next_state     = ST_HOLDOVER; // R4
               next_exit_wait = '0;
            end else if (!lock_flag) begin
               next_state = ST_ACQUIRE;
            end
         end
         ST_HOLDOVER: begin
            // With mode code two kept, exit needs the reference seen valid for a few cycles, which
            // filters a glitchy pin; chatter is still possible if the count is short.
            if (!holdover_on) begin
               next_state = ST_ACQUIRE;
               restart    = 1'b1;
            end else if (!ref_sync_b) begin
               next_exit_wait = '0;
            end else if (exit_wait == 2'(EXIT_WAIT_CYCLES - 1)) begin
               next_state = ST_ACQUIRE; // R5
               restart    = 1'b1;
            end else begin
               next_exit_wait = exit_wait + 2'h1;
            end
         end
         // The unused code can only come from an upset; recover through acquire.
         default: begin
            next_state = ST_ACQUIRE;
         end
      endcase
   end

   always_comb begin
      next_dac = dac;
      if (state != ST_HOLDOVER) begin
         next_dac = loop_dac_in;
      end else if (fixed_voltage_enable_in) begin
         next_dac = fixed_voltage_code_in; // R8 R9
      end else if (track_enable_in) begin
         next_dac = dac;
      end
      // Tracking off: the value captured on entry is simply held.
      if (state == ST_HOLDOVER && !track_enable_in && !fixed_voltage_enable_in) begin
         next_dac = dac; // R7
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state     <= ST_ACQUIRE;
         exit_wait <= 2'h0;
         dac       <= D_W'(RST_DAC_CODE); // R9
      end else begin
         state     <= next_state;
         exit_wait <= next_exit_wait;
         dac       <= next_dac;
      end
   end

   assign lock_flag_out    = lock_flag;
   assign holdover_out     = state == ST_HOLDOVER;
   assign loop_restart_out = restart;
   assign vcxo_dac_out     = dac;

   sequence s_lock_lost;
      state == ST_LOCKED && !lock_flag && trigger;
   endsequence

   sequence s_ref_back;
      (state == ST_HOLDOVER && holdover_on && ref_sync_b) [*2];
   endsequence

   sequence s_mode_off;
      state == ST_HOLDOVER && !holdover_on;
   endsequence

   a_enter_holdover: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      s_lock_lost |=> holdover_out) // R4
      else $error("holdover not entered on lock loss");
   a_no_trigger_off: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (state == ST_LOCKED && lock_loss_trigger_off_in) |=> !holdover_out) // R4
      else $error("holdover entered with trigger disabled");
   a_mode_gate: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (holdover_mode_in != MODE_HOLDOVER_ON && state != ST_HOLDOVER) |=> !holdover_out) // R6
      else $error("holdover without mode two");
   a_exit_holdover: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      s_ref_back |-> loop_restart_out ##1 !holdover_out) // R5
      else $error("holdover not left on valid reference");
   a_fixed_dac: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (holdover_out && fixed_voltage_enable_in) |=>
         vcxo_dac_out == $past(fixed_voltage_code_in)) // R8
      else $error("fixed code not driven in holdover");
   a_track_frozen: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (holdover_out && !track_enable_in && !fixed_voltage_enable_in) |=> $stable(vcxo_dac_out)) // R7
      else $error("dac moved with tracking off");

   // The restart pulse is what clears the qualifier, so it must only come out
   // of holdover and must leave the lock flag low behind it.
   a_restart_in_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      loop_restart_out |-> holdover_out) // R5
      else $error("restart pulse outside holdover");
   a_restart_clears: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      loop_restart_out |=> !lock_flag_out) // R11
      else $error("lock flag kept after restart");
   a_hold_without_ref: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (holdover_out && holdover_on && !ref_sync_b) |=> holdover_out) // R5
      else $error("holdover left without valid reference");
   a_mode_exit: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      s_mode_off |-> loop_restart_out ##1 !holdover_out) // R6
      else $error("holdover kept after mode change");
   a_dac_tracks: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !holdover_out |=> vcxo_dac_out == $past(loop_dac_in)) // R7
      else $error("dac not following loop outside holdover");
   a_flag_holds: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (lock_flag_out && in_window && !restart) |=> lock_flag_out) // R2
      else $error("lock flag dropped inside window");
   a_locked_stays: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      (state == ST_LOCKED && lock_flag) |=> !holdover_out) // R4
      else $error("holdover entered with lock flag high");
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lock_holdover_pkg::*;
   logic                core_clk_in;
   logic                arst_n_in;
   logic [PHASE_W-1:0]  phase_error_in;
   logic                ref_valid_in;
   logic [DAC_W-1:0]    loop_dac_in;
   logic [COUNT_W-1:0]  lock_qualify_count_in;
   logic [PHASE_W-1:0]  phase_window_size_in;
   logic                lock_loss_trigger_off_in;
   logic [MODE_W-1:0]   holdover_mode_in;
   logic                track_enable_in;
   logic                fixed_voltage_enable_in;
   logic [DAC_W-1:0]    fixed_voltage_code_in;
   logic                lock_flag_out;
   logic                holdover_out;
   logic                loop_restart_out;
   logic [DAC_W-1:0]    vcxo_dac_out;
   logic [11:0]         notes[$];
   logic                last_lock;
   logic                last_hold;
   logic [MODE_W-1:0]   modes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   logic [COUNT_W-1:0]  cnt;
   logic [DAC_W-1:0]    cap;
   int                  win;
   int                  miscompares = 0;
   int                  checks = 0;

   pll_lock_detect_holdover pll_lock_detect_holdover_inst (.core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in), .phase_error_in(phase_error_in), .ref_valid_in(ref_valid_in),
      .loop_dac_in(loop_dac_in), .lock_qualify_count_in(lock_qualify_count_in),
      .phase_window_size_in(phase_window_size_in),
      .lock_loss_trigger_off_in(lock_loss_trigger_off_in), .holdover_mode_in(holdover_mode_in),
      .track_enable_in(track_enable_in), .fixed_voltage_enable_in(fixed_voltage_enable_in),
      .fixed_voltage_code_in(fixed_voltage_code_in), .lock_flag_out(lock_flag_out),
      .holdover_out(holdover_out), .loop_restart_out(loop_restart_out),
      .vcxo_dac_out(vcxo_dac_out));

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // An event with no note waiting reads as kind 3, which never matches.
   task automatic take(input logic [1:0] k, input logic [9:0] v);
      logic [11:0] e;
      e = (notes.size() == 0) ? 12'hfff : notes.pop_front();
      check("event kind", {8'h00, e[11:10]}, {8'h00, k});
      check("event value", e[9:0], v);
   endtask

   // Every change of a status output must match the oldest note.
   always @(negedge core_clk_in) begin
      if (arst_n_in) begin
         if (lock_flag_out !== last_lock) take(2'h0, {9'h000, lock_flag_out});
         if (holdover_out !== last_hold) take(2'h1, {9'h000, holdover_out});
         if (loop_restart_out === 1'b1) take(2'h2, 10'h001);
      end
      last_lock = lock_flag_out;
      last_hold = holdover_out;
   end

   function automatic logic sig(input logic [1:0] k);
      case (k)
         2'h0: return lock_flag_out;
         2'h1: return holdover_out;
         default: return loop_restart_out;
      endcase
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask

   task automatic note(input logic [1:0] k, input logic [9:0] v);
      notes.push_back({k, v});
   endtask

   task automatic wait_for(input logic [1:0] k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v && n < 200) begin
         tick(1);
         n++;
      end
      if (n >= 200) begin
         miscompares++;
         test_done();
      end
   endtask

   task automatic in_win();
      phase_error_in = 8'($urandom_range(0, win));
   endtask

   task automatic out_win();
      phase_error_in = 8'($urandom_range(win + 1, 255));
   endtask

   // One out-of-window sample first, so every lock starts from an empty count.
   task automatic lock_up(input logic [COUNT_W-1:0] c);
      lock_qualify_count_in = c;
      out_win();
      tick(1);
      in_win();
      tick(int'(c));
      check("early lock", 10'h000, {9'h000, lock_flag_out});
      note(2'h0, 10'h001);
      tick(1);
      check("lock time", 10'h001, {9'h000, lock_flag_out});
      wait_for(2'h0, 1'b1);
   endtask

   task automatic lose(input logic hold);
      out_win();
      note(2'h0, 10'h000);
      if (hold) note(2'h1, 10'h001);
      wait_for(2'h0, 1'b0);
      tick(6);
   endtask

   task automatic leave();
      note(2'h2, 10'h001);
      note(2'h1, 10'h000);
      ref_valid_in = 1'b1;
      wait_for(2'h1, 1'b0);
   endtask

   initial begin
      void'($urandom(32'h760e67d8));
      arst_n_in = 1'b0;
      win = $urandom_range(8, 200);
      phase_window_size_in = 8'(win);
      phase_error_in = 8'hff;
      ref_valid_in = 1'b1;
      loop_dac_in = 10'($urandom_range(0, 511));
      lock_qualify_count_in = 14'h0001;
      lock_loss_trigger_off_in = 1'b0;
      holdover_mode_in = 2'h0;
      track_enable_in = 1'b1;
      fixed_voltage_enable_in = 1'b0;
      fixed_voltage_code_in = 10'($urandom);
      tick(20);
      arst_n_in = 1'b1;
      check("reset dac", RST_DAC_CODE, vcxo_dac_out);
      cnt = 14'($urandom_range(5, 12));
      lock_qualify_count_in = cnt;
      in_win();
      tick(int'(cnt) - 1);
      out_win();
      tick(1);
      in_win();
      tick(int'(cnt) - 1);
      check("interrupted run", 10'h000, {9'h000, lock_flag_out});
      lock_up(cnt);
      for (int i = 0; i < 4; i++) begin
         holdover_mode_in = modes[i];
         lock_loss_trigger_off_in = (i == 3);
         lose(1'b0);
         lock_up(14'($urandom_range(1, 30)));
      end
      lock_loss_trigger_off_in = 1'b0;
      fixed_voltage_enable_in = 1'b1;
      fixed_voltage_code_in = 10'h200;
      ref_valid_in = 1'b0;
      lose(1'b1);
      check("fixed dac", 10'h200, vcxo_dac_out);
      leave();
      // A longer count after holdover keeps a settling loop from chattering.
      lock_up(14'h0040);
      fixed_voltage_enable_in = 1'b0;
      track_enable_in = 1'b0;
      cap = loop_dac_in;
      ref_valid_in = 1'b0;
      lose(1'b1);
      loop_dac_in = ~cap;
      tick(4);
      check("held dac", cap, vcxo_dac_out);
      leave();
      lock_up(14'h0002);
      tick(4);
      check("tracked dac", ~cap, vcxo_dac_out);
      // The mode change lands after the negedge sample, so the restart pulse, high
      // only until the next posedge, is left to the design's assertions here.
      ref_valid_in = 1'b0;
      lose(1'b1);
      note(2'h1, 10'h000);
      holdover_mode_in <= 2'h0;
      wait_for(2'h1, 1'b0);
      tick(4);
      check("notes left", 10'h000, 10'(notes.size()));
      test_done();
   end
endmodule
`default_nettype wire
